// *** design/scp_pkg.sv ***
`default_nettype none
package scp_pkg;
    // Register byte addresses on the Wishbone bus (printed offsets not all /4)
    localparam logic [7:0] PRESCALE_IDX   = 8'h61;
    localparam logic [7:0] TRIM_IDX       = 8'h66;
    localparam logic [7:0] TIMER_CTRL_IDX = 8'h68;
    localparam logic [7:0] STATUS_IDX     = 8'h69;
    localparam logic [9:0] PRESCALE_ADDR  = {PRESCALE_IDX, 2'b00};
    localparam logic [9:0] TRIM_ADDR      = {TRIM_IDX, 2'b00};
    localparam logic [9:0] TIMER_CTRL_ADDR = {TIMER_CTRL_IDX, 2'b00};
    localparam logic [9:0] STATUS_ADDR    = {STATUS_IDX, 2'b00};
    // Field positions
    localparam int CHANGE_EN_BIT   = 7;
    localparam int EXT_CLK_BIT     = 0;
    localparam int TIMER_OSC_BIT   = 1;
    // Reset values and largest code of the select field
    localparam logic [3:0] SEL_RESET_UNPROG = 4'h0;
    localparam logic [3:0] SEL_RESET_DIV8   = 4'h3;
    localparam logic [3:0] SEL_MAX          = 4'h8;
    // Unlock window length in cycles
    localparam logic [2:0] UNLOCK_CYCLES    = 3'h4;
    // Unmapped reads return zero
    localparam logic [31:0] READ_UNMAPPED   = 32'h0000_0000;

    // Clock enables toward the four clock domains
    typedef struct packed {
        logic io_en;
        logic adc_en;
        logic core_en;
        logic flash_en;
    } scp_domain_s;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_WAIT1 = 3'b010,
        ST_WAIT2 = 3'b100
    } scp_switch_e;
endpackage : scp_pkg
`default_nettype wire

// *** design/scp_prescaler.sv ***
// Operation
// R1: Software keeps system clock at least four times the timer oscillator.
// R2: Timer oscillator usable only while internal RC oscillator is selected.
// R3: External clock bit lets the timer input pin take an external clock.
// R4: Clock output fuse drives system clock on output pin, even in reset; the pin here carries clk_div_reg, held low in reset.
// R5: With division active the output pin carries the divided clock.
// R6: Divided clock gates I/O, converter, core and memory domains alike.
// R7: Division changes produce no glitch and no faster intermediate rate.
// R8: Prescaler counter runs at source rate and is not software readable.
// R9: New rate starts after two edges, between T1+T2 and T1+2*T2.
// R10: Software writes 0x80, then select with enable clear within four cycles.
// R11: Change enable is set only by a write with all other bits zero.
// R12: Change enable clears after four cycles or on select write.
// R13: Rewriting change enable in its window neither restarts nor clears it.
// R14: Reset loads select 0000, or 0011 when divide-by-eight fuse programmed.
// R15: Any select value may be written regardless of the fuse.
// R16: Select code n divides by 2**n for codes up to 1000.
// R17: Reset loads the factory calibration value into the trim register.
// R18: Top trim bit picks low or high range; the ranges overlap.
// R19: Lower seven trim bits tune frequency monotonically in range.
// R20: Software keeps trim at or below 8.8MHz during memory writes.
// R21: Software disables interrupts during the two-write change sequence.
// R22: Unused prescaler bits read zero; reserved select codes undefined.
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
module scp_prescaler #(
    parameter logic [7:0] FACTORY_TRIM = 8'h80, // Arbitrary calibration value
    parameter int         CNT_W        = 8
) (
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    // Classic Wishbone slave
    input  wire logic               wb_cyc_in,
    input  wire logic               wb_stb_in,
    input  wire logic               wb_we_in,
    input  wire logic [9:0]         wb_adr_in,
    input  wire logic [3:0]         wb_sel_in,
    input  wire logic [31:0]        wb_dat_in,
    output logic      [31:0]        wb_dat_out,
    output logic                    wb_ack_out,
    // Fuses and clock-source status (static pins)
    input  wire logic               div8_fuse_in,
    input  wire logic               clock_output_fuse_in,
    input  wire logic               rc_osc_selected_in,
    // Clock enables for the four domains
    output scp_pkg::scp_domain_s    domain_en_out,
    // Clock output pin: data and enable (enable low drives)
    output logic                    clock_output_pin_out,
    output logic                    clock_output_oe_n_out,
    // Trim word toward the RC oscillator
    output logic      [7:0]         rc_trim_out,
    // Timer oscillator pin control
    output logic                    timer_osc_enable_out,
    output logic                    timer_ext_clock_enable_out
);
    import scp_pkg::*;

    // Reset release through two flip-flops
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rstn = rst_sync_reg;

    // Fuse and status pin synchronisers
    // No reset here: the fuses must be valid while reset is still held,
    // so the select load and the clock pin see them at release
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    always_ff @(posedge clk_in)
    begin
        pin_meta_reg <= {rc_osc_selected_in, clock_output_fuse_in,
                         div8_fuse_in};
        pin_sync_reg <= pin_meta_reg;
    end
    wire logic div8_fuse  = pin_sync_reg[0];
    wire logic clock_output_fuse_fuse = pin_sync_reg[1];
    wire logic rc_sel     = pin_sync_reg[2];

    // Bus decode
    wire logic req       = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire logic wr_lane0  = req & wb_we_in & wb_sel_in[0];
    wire logic hit_pre   = (wb_adr_in == PRESCALE_ADDR);
    wire logic hit_trim  = (wb_adr_in == TRIM_ADDR);
    wire logic hit_tctl  = (wb_adr_in == TIMER_CTRL_ADDR);
    wire logic hit_stat  = (wb_adr_in == STATUS_ADDR);
    wire logic [7:0] wb_byte = wb_dat_in[7:0];
    wire logic wr_pre    = wr_lane0 & hit_pre;
    wire logic wr_trim   = wr_lane0 & hit_trim;
    wire logic wr_tctl   = wr_lane0 & hit_tctl;
    wire logic unlock_wr = wr_pre & (wb_byte == 8'h80);        // see R11
    wire logic sel_wr    = wr_pre & ~wb_byte[CHANGE_EN_BIT];

    // Change-enable window and select register
    logic       change_en_reg;
    logic [2:0] win_cnt_reg;
    logic [3:0] sel_reg;
    logic       sel_loaded_reg;
    wire logic  win_done  = (win_cnt_reg == UNLOCK_CYCLES - 3'h1);
    wire logic  accept_sel = change_en_reg & sel_wr;          // see R10
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            change_en_reg <= 1'b0;
            win_cnt_reg   <= 3'h0;
        end
        else if (change_en_reg)
        begin
            // Rewrite of 0x80 is ignored here: window keeps running
            if (accept_sel || win_done)                       // see R12 R13
                change_en_reg <= 1'b0;
            win_cnt_reg <= win_cnt_reg + 3'h1;
        end
        else if (unlock_wr)                                   // see R11
        begin
            change_en_reg <= 1'b1;
            win_cnt_reg   <= 3'h0;
        end
    end

    // Select loads from the fuse once after reset release, then software
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_reg        <= SEL_RESET_UNPROG;
            sel_loaded_reg <= 1'b0;
        end
        else if (!sel_loaded_reg)
        begin
            sel_loaded_reg <= 1'b1;
            sel_reg <= div8_fuse ? SEL_RESET_DIV8 : SEL_RESET_UNPROG; // see R14
        end
        else if (accept_sel)
            sel_reg <= wb_byte[3:0];                          // see R15
    end

    // Trim register: factory value at reset, software may overwrite
    logic [7:0] trim_reg;
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
            trim_reg <= FACTORY_TRIM;                         // see R17
        else if (wr_trim)
            trim_reg <= wb_byte;                              // see R18 R19
    end

    // Timer oscillator control: bit0 external clock, bit1 oscillator on
    logic [1:0] tctl_reg;
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
            tctl_reg <= 2'h0;
        else if (wr_tctl)
            tctl_reg <= {wb_byte[TIMER_OSC_BIT], wb_byte[EXT_CLK_BIT]};
    end

    // Glitch-free switch: apply new select only at a divided-clock edge
    logic [CNT_W-1:0] cnt_reg;
    logic [3:0]       act_sel_reg;
    scp_switch_e      sw_reg;
    // Reserved codes saturate to the largest division
    wire logic [3:0] act_clamp = (act_sel_reg > SEL_MAX) ? SEL_MAX
                                                         : act_sel_reg;
    wire logic [CNT_W:0] full = (CNT_W+1)'(1) << act_clamp;    // see R16 R22
    wire logic [CNT_W:0] cnt_ext = {1'b0, cnt_reg};
    wire logic tick = (cnt_ext == full - (CNT_W+1)'(1));        // see R8
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= '0;
        else if (tick)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + CNT_W'(1);
    end

    // Apply the new select at the end of the old period, then wait out one new period
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            sw_reg      <= ST_RUN;
            act_sel_reg <= SEL_RESET_UNPROG;
        end
        else
        begin
            case (sw_reg)
                ST_RUN:
                    if (sel_reg != act_sel_reg)
                        sw_reg <= ST_WAIT1;
                ST_WAIT1:
                    if (tick)                                 // see R9
                    begin
                        act_sel_reg <= sel_reg;               // see R7
                        sw_reg      <= ST_WAIT2;
                    end
                ST_WAIT2:
                    if (tick)                                 // see R9
                        sw_reg <= ST_RUN;
                default:
                    sw_reg <= ST_RUN;
            endcase
        end
    end

    // Domain enables and divided clock toggle for the output pin
    logic clk_div_reg;
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            domain_en_out <= '0;
            clk_div_reg   <= 1'b0;
        end
        else
        begin
            domain_en_out <= '{io_en: tick, adc_en: tick,
                               core_en: tick, flash_en: tick}; // see R6
            if (tick)
                clk_div_reg <= ~clk_div_reg;                  // see R5
        end
    end

    // Clock output pin; no reset, so the fuse keeps the pin driven in reset
    always_ff @(posedge clk_in)
    begin
        clock_output_pin_out  <= clk_div_reg;                 // see R4 R5
        clock_output_oe_n_out <= ~clock_output_fuse_fuse;                 // see R4
    end

    // Timer pins follow control only while RC oscillator is the source
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_osc_enable_out       <= 1'b0;
            timer_ext_clock_enable_out <= 1'b0;
            rc_trim_out                <= FACTORY_TRIM;
        end
        else
        begin
            timer_osc_enable_out       <= tctl_reg[1] & rc_sel; // see R2
            timer_ext_clock_enable_out <= tctl_reg[0] & rc_sel; // see R3
            rc_trim_out                <= trim_reg;
        end
    end

    // Read data mux; unused bits 6:4 read zero
    wire logic [7:0] pre_rd  = {change_en_reg, 3'h0, sel_reg}; // see R22
    wire logic [7:0] stat_rd = {4'h0, act_sel_reg != sel_reg,
                                rc_sel, clock_output_fuse_fuse, div8_fuse};
    wire logic [7:0] rd_byte = hit_pre  ? pre_rd :
                               hit_trim ? trim_reg :
                               hit_tctl ? {6'h0, tctl_reg} :
                               hit_stat ? stat_rd : 8'h00;
    always_ff @(posedge clk_in or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= READ_UNMAPPED;
        end
        else
        begin
            wb_ack_out <= req;
            wb_dat_out <= req ? {24'h0, rd_byte} : READ_UNMAPPED;
        end
    end
endmodule : scp_prescaler
`default_nettype wire

// *** verif/scp_prescaler_monitor.sv ***
`default_nettype none
// Bus handshake, clock pin, timer gating and trim checks
module scp_prescaler_monitor (
    input wire logic                 clk_in,
    input wire logic                 resetn_in,
    input wire logic                 wb_cyc_in,
    input wire logic                 wb_stb_in,
    input wire logic                 wb_we_in,
    input wire logic [9:0]           wb_adr_in,
    input wire logic [3:0]           wb_sel_in,
    input wire logic [31:0]          wb_dat_in,
    input wire logic [31:0]          wb_dat_out,
    input wire logic                 wb_ack_out,
    input wire logic                 clock_output_fuse_in,
    input wire logic                 rc_osc_selected_in,
    input wire scp_pkg::scp_domain_s domain_en_out,
    input wire logic                 clock_output_oe_n_out,
    input wire logic [7:0]           rc_trim_out,
    input wire logic                 timer_osc_enable_out,
    input wire logic                 timer_ext_clock_enable_out
);
    import scp_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // A request taken, and a taken write of the trim byte
    sequence s_take;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_trim_wr;
        s_take ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in == TRIM_ADDR);
    endsequence
    // Checks
    a_ack_follows: assert property (s_take |=> wb_ack_out)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_ack_spurious: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_domains_equal: assert property (
        domain_en_out.io_en == domain_en_out.adc_en &&
        domain_en_out.core_en == domain_en_out.flash_en &&
        domain_en_out.io_en == domain_en_out.core_en)
        else $error("domain enables differ");
    a_fuse_drives: assert property (
        clock_output_fuse_in [*5] |-> !clock_output_oe_n_out)
        else $error("clock pin not driven");
    a_osc_gated: assert property (
        !rc_osc_selected_in [*5] |->
        !timer_osc_enable_out && !timer_ext_clock_enable_out)
        else $error("timer oscillator on without rc source");
    a_trim_write: assert property (
        s_trim_wr |-> ##2 rc_trim_out == $past(wb_dat_in[7:0], 2))
        else $error("trim not written");
endmodule : scp_prescaler_monitor

bind scp_prescaler scp_prescaler_monitor i_mon (
    .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .clock_output_fuse_in(clock_output_fuse_in),
    .rc_osc_selected_in(rc_osc_selected_in), .domain_en_out(domain_en_out),
    .clock_output_oe_n_out(clock_output_oe_n_out),
    .rc_trim_out(rc_trim_out), .timer_osc_enable_out(timer_osc_enable_out),
    .timer_ext_clock_enable_out(timer_ext_clock_enable_out));
`default_nettype wire

// *** verif/system_clock_prescaler_bench.sv ***
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", nm, e, g); \
        end \
    end
module system_clock_prescaler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import scp_pkg::*;
    logic        clk_in, resetn_in, wb_cyc_in, wb_stb_in, wb_we_in;
    logic        wb_ack_out, div8_fuse_in, clock_output_fuse_in;
    logic        rc_osc_selected_in, clock_output_pin_out;
    logic        clock_output_oe_n_out, timer_osc_enable_out;
    logic        timer_ext_clock_enable_out;
    logic [9:0]  wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out;
    logic [7:0]  rc_trim_out, rd_val;
    scp_domain_s domain_en_out;
    int          bad_count = 0, total_checks = 0, per;

    scp_prescaler i_dut (.clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in,
        .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
        .wb_ack_out, .div8_fuse_in, .clock_output_fuse_in,
        .rc_osc_selected_in, .domain_en_out, .clock_output_pin_out,
        .clock_output_oe_n_out, .rc_trim_out, .timer_osc_enable_out,
        .timer_ext_clock_enable_out);

    // Free-running 10 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // One classic bus cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= {24'h0, d};
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (wb_ack_out !== 1'b1 && n < 20);
        if (wb_ack_out !== 1'b1)
            bad_count++;
        rd_val = wb_dat_out[7:0];
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask : bus

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK("read data", e, rd_val)
    endtask : rd

    // Cycles between two domain enable pulses
    task automatic period(output int p);
        int n;
        n = 0;
        p = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (domain_en_out.io_en !== 1'b1 && n < 600);
        do
        begin
            @(posedge clk_in);
            p++;
        end
        while (domain_en_out.io_en !== 1'b1 && p < 600);
    endtask : period

    task automatic restart(input logic f8, input logic fo);
        resetn_in <= 1'b0;
        div8_fuse_in <= f8;
        clock_output_fuse_in <= fo;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask : restart

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // Watchdog
    initial
    begin
        repeat (30000) @(posedge clk_in);
        bad_count++;
        end_of_test();
    end

    // Test sequence
    initial
    begin
        resetn_in = 1'b0;
        {wb_cyc_in, wb_stb_in, wb_we_in} = 3'h0;
        wb_adr_in = 10'h0;
        wb_sel_in = 4'h1;
        wb_dat_in = 32'h0;
        rc_osc_selected_in = 1'b1;
        restart(1'b1, 1'b1);
        rd(PRESCALE_ADDR, 8'h03);
        rd(TRIM_ADDR, 8'h80);
        rd(10'h3fc, 8'h00);
        `CHK("pin enable", 1'b0, clock_output_oe_n_out)
        period(per);
        period(per);
        `CHK("period", 8, per)
        $display("reset test done");
        bus(1'b1, PRESCALE_ADDR, 8'h01);
        bus(1'b1, PRESCALE_ADDR, 8'h81);
        bus(1'b1, PRESCALE_ADDR, 8'h01);
        rd(PRESCALE_ADDR, 8'h03);
        bus(1'b1, PRESCALE_ADDR, 8'h80);
        rd(PRESCALE_ADDR, 8'h83);
        bus(1'b1, PRESCALE_ADDR, 8'h01);
        rd(PRESCALE_ADDR, 8'h03);
        bus(1'b1, PRESCALE_ADDR, 8'h80);
        bus(1'b1, PRESCALE_ADDR, 8'h80);
        bus(1'b1, PRESCALE_ADDR, 8'h01);
        rd(PRESCALE_ADDR, 8'h03);
        bus(1'b1, PRESCALE_ADDR, 8'h80);
        bus(1'b1, PRESCALE_ADDR, 8'h74);
        rd(PRESCALE_ADDR, 8'h04);
        $display("unlock test done");
        for (int c = 0; c <= 8; c++)
        begin
            bus(1'b1, PRESCALE_ADDR, 8'h80);
            bus(1'b1, PRESCALE_ADDR, 8'(c));
            period(per);
            period(per);
            `CHK("period", 1 << c, per)
        end
        $display("divide test done");
        bus(1'b1, TRIM_ADDR, 8'h7f);
        rd(TRIM_ADDR, 8'h7f);
        `CHK("trim", 8'h7f, rc_trim_out)
        bus(1'b1, TIMER_CTRL_ADDR, 8'h03);
        repeat (4) @(posedge clk_in);
        `CHK("timer osc", 1'b1, timer_osc_enable_out)
        `CHK("ext clock", 1'b1, timer_ext_clock_enable_out)
        rc_osc_selected_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        `CHK("timer osc", 1'b0, timer_osc_enable_out)
        $display("timer test done");
        restart(1'b0, 1'b0);
        rd(PRESCALE_ADDR, 8'h00);
        rd(TRIM_ADDR, 8'h80);
        `CHK("pin enable", 1'b1, clock_output_oe_n_out)
        $display("fuse test done");
        end_of_test();
    end
endmodule : system_clock_prescaler_bench
`default_nettype wire
